/* core/xiep_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "xiep_consts.vh"

module xiep_ctrl #(
  parameter SOURCES = 8
) (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Special function register port.
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  // Peripheral request flags.
  input wire timer_three_low_overflow_flag,
  input wire timer_three_high_overflow_flag,
  input wire comparator_one_rising_flag,
  input wire comparator_one_falling_flag,
  input wire comparator_zero_rising_flag,
  input wire comparator_zero_falling_flag,
  input wire counter_array_req,
  input wire conversion_done_flag,
  input wire window_compare_flag,
  input wire port_match_req,
  input wire smbus_controller_req,
  // Core interrupt logic.
  input wire global_irq_enable,
  input wire irq_ack,
  input wire irq_return,
  output reg irq_req,
  output reg irq_high,
  output reg [2:0] irq_source,
  output reg [7:0] irq_pending,
  output reg high_in_service,
  output reg low_in_service
);

  reg [7:0] extended_irq_enable;
  reg [7:0] extended_irq_priority;
  reg [7:0] raw_req;
  wire [7:0] next_pending;
  wire [7:0] high_set;
  wire [7:0] low_set;
  wire any_high;
  wire any_low;
  wire enable_hit;
  wire priority_hit;
  reg [2:0] high_pick;
  reg [2:0] low_pick;
  reg next_req;
  reg next_high;
  reg [2:0] next_source;
  reg next_high_svc;
  reg next_low_svc;
  reg [7:0] next_rdata;
  integer i;

  // Each source collapses its flags into one request line. The flags are levels that the
  // peripherals hold until software clears them, so this block keeps no sticky copy and has
  // no set against clear race to resolve.
  always @* begin
    raw_req = 8'h00;
    raw_req[`XIEP_BIT_TIMER_THREE] = timer_three_low_overflow_flag |
      timer_three_high_overflow_flag;
    raw_req[`XIEP_BIT_COMPARATOR_ONE] = comparator_one_rising_flag |
      comparator_one_falling_flag;
    raw_req[`XIEP_BIT_COMPARATOR_ZERO] = comparator_zero_rising_flag |
      comparator_zero_falling_flag;
    raw_req[`XIEP_BIT_COUNTER_ARRAY] = counter_array_req;
    raw_req[`XIEP_BIT_CONVERSION_DONE] = conversion_done_flag;
    raw_req[`XIEP_BIT_WINDOW_COMPARE] = window_compare_flag;
    raw_req[`XIEP_BIT_PORT_MATCH] = port_match_req;
    raw_req[`XIEP_BIT_SMBUS] = smbus_controller_req;
  end

  // Per source gating by its own mask bit and the global enable, split by level. The pending
  // view already includes the global enable, so it shows exactly what could interrupt.
  genvar g;
  generate
    for (g = 0; g < SOURCES; g = g + 1) begin : gate
      assign next_pending[g] = raw_req[g] & extended_irq_enable[g] & global_irq_enable;
      assign high_set[g] = next_pending[g] & extended_irq_priority[g];
      assign low_set[g] = next_pending[g] & ~extended_irq_priority[g];
    end
  endgenerate

  assign any_high = |high_set;
  assign any_low = |low_set;

  // One encoder per level. The loop runs upward and keeps the last hit, so the highest bit
  // wins within a level and timer three goes first.
  // The fixed order inside a level is a choice; any order there would meet the rules.
  always @* begin
    high_pick = 3'h0;
    low_pick = 3'h0;
    for (i = 0; i < SOURCES; i = i + 1) begin
      if (high_set[i]) begin
        high_pick = i[2:0];
      end
      if (low_set[i]) begin
        low_pick = i[2:0];
      end
    end
  end

  // Selection: a high level request wins over any low level one. It is offered even while
  // a low routine runs, which is how it preempts; nothing is offered while a high routine
  // runs, since nothing can preempt it. The decision uses the in-service state as it will
  // stand after this edge, so a request acknowledged now is withdrawn on the same edge and
  // the core can never take it a second time.
  always @* begin
    next_req = 1'b0;
    next_high = 1'b0;
    next_source = 3'h0;
    if (!next_high_svc) begin
      if (any_high) begin
        next_req = 1'b1;
        next_high = 1'b1;
        next_source = high_pick;
      end else if (any_low && !next_low_svc) begin
        next_req = 1'b1;
        next_source = low_pick;
      end
    end
  end

  // In-service tracking. An acknowledge marks the level presented in that cycle; a
  // return closes the innermost routine, which is the high one when both are open.
  // When both fall in one cycle the return is applied first, then the acknowledge.
  // A return with no routine open changes nothing.
  always @* begin
    next_high_svc = high_in_service;
    next_low_svc = low_in_service;
    if (irq_return) begin
      if (high_in_service) begin
        next_high_svc = 1'b0;
      end else begin
        next_low_svc = 1'b0;
      end
    end
    if (irq_ack && irq_req) begin
      if (irq_high) begin
        next_high_svc = 1'b1;
      end else begin
        next_low_svc = 1'b1;
      end
    end
  end

  // Address decode, shared by the write and the read path so that both always agree on
  // which register an address names.
  assign enable_hit = (sfr_addr == `XIEP_ENABLE_ADDR);
  assign priority_hit = (sfr_addr == `XIEP_PRIORITY_ADDR);

  // Register writes. A write to any other address is dropped without a trace, since the
  // register port has no way to report an error.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extended_irq_enable <= `XIEP_ENABLE_RESET;
      extended_irq_priority <= `XIEP_PRIORITY_RESET;
    end else if (sfr_wr) begin
      if (enable_hit) begin
        extended_irq_enable <= sfr_wdata;
      end
      if (priority_hit) begin
        extended_irq_priority <= sfr_wdata;
      end
    end
  end

  // Read data is chosen here and registered below, so it stands for the one cycle after the
  // strobe. Any other address answers zero so a shared read mux can OR ports.
  always @* begin
    next_rdata = 8'h00;
    if (sfr_rd) begin
      if (enable_hit) begin
        next_rdata = extended_irq_enable;
      end
      if (priority_hit) begin
        next_rdata = extended_irq_priority;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= `XIEP_RDATA_RESET;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

  // Outputs to the core. Every one is registered so the core sees clean levels; the price
  // is one cycle from a flag to its request.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req <= 1'b0;
      irq_high <= 1'b0;
      irq_source <= 3'h0;
      irq_pending <= 8'h00;
    end else begin
      irq_req <= next_req;
      irq_high <= next_high;
      irq_source <= next_source;
      irq_pending <= next_pending;
    end
  end

  // Service state, moved on the same edge as the request so the two never disagree.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      high_in_service <= 1'b0;
      low_in_service <= 1'b0;
    end else begin
      high_in_service <= next_high_svc;
      low_in_service <= next_low_svc;
    end
  end

endmodule // xiep_ctrl
`default_nettype wire

/* core/xiep_consts.vh */
// How it works
// - Enable bit 7 lets timer three requests from either overflow flag through when 1.
// - Enable bit 6 lets comparator one rising or falling requests through when 1.
// - Enable bit 5 lets comparator zero rising or falling requests through when 1.
// - Enable bit 4 lets every counter array request through when 1.
// - Enable bit 3 lets the conversion done request through when 1.
// - Enable bit 2 lets the window compare request through when 1.
// - Enable bit 1 lets port match requests through when 1.
// - Enable bit 0 lets every smbus controller request through when 1.
// - A priority bit of 0 means low level and 1 high level, bit 7 for timer three.
// - Priority bit 6 serves comparator one and bit 5 comparator zero.
// - Priority bit 4 serves the counter array and bit 3 conversion done.
// - Priority bits 2, 1 and 0 serve window compare, port match and smbus.
// - The priority register is fully read and write and resets to all zero.
// - No source interrupts while the global enable is clear.
`ifndef XIEP_CONSTS_VH
`define XIEP_CONSTS_VH

`define XIEP_ENABLE_ADDR 8'hE6
`define XIEP_PRIORITY_ADDR 8'hF3
`define XIEP_ENABLE_RESET 8'h00
`define XIEP_PRIORITY_RESET 8'h00
`define XIEP_RDATA_RESET 8'h00

`define XIEP_BIT_TIMER_THREE 7
`define XIEP_BIT_COMPARATOR_ONE 6
`define XIEP_BIT_COMPARATOR_ZERO 5
`define XIEP_BIT_COUNTER_ARRAY 4
`define XIEP_BIT_CONVERSION_DONE 3
`define XIEP_BIT_WINDOW_COMPARE 2
`define XIEP_BIT_PORT_MATCH 1
`define XIEP_BIT_SMBUS 0

`endif

/* verification/xiep_core.sv */
`timescale 1ns/1ps
`default_nettype none
module xiep_core (input wire logic clk, input wire logic en, input wire logic rq,
  output logic ak);
  initial ak = 1'b0;
  // The acknowledge is launched on the rising edge, so it never races the bench's stimulus.
  always @(posedge clk) ak <= en && rq && !ak;
endmodule // xiep_core
`default_nettype wire

/* verification/xiep_chk_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module xiep_chk (input wire logic clk, input wire logic arst_n, input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata, input wire logic conversion_done_flag,
  input wire logic smbus_controller_req, input wire logic global_irq_enable,
  input wire logic irq_ack, input wire logic irq_req, input wire logic irq_high,
  input wire logic [2:0] irq_source, input wire logic [7:0] irq_pending,
  input wire logic high_in_service, input wire logic low_in_service);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_hi_ack; irq_req && irq_high && irq_ack; endsequence
  property p_glob; !global_irq_enable |=> !irq_pending; endproperty
  a_glob: assert property (p_glob) else $error("glob");
  property p_src; irq_req |-> irq_pending[irq_source]; endproperty
  a_src: assert property (p_src) else $error("src");
  property p_hi; s_hi_ack |=> high_in_service; endproperty
  a_hi: assert property (p_hi) else $error("hi");
  property p_hblk; high_in_service |-> !irq_req; endproperty
  a_hblk: assert property (p_hblk) else $error("hblk");
  property p_lblk; low_in_service && irq_req |-> irq_high; endproperty
  a_lblk: assert property (p_lblk) else $error("lblk");
  property p_rd; !sfr_rd |=> !sfr_rdata; endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_cd; !conversion_done_flag |=> !irq_pending[3]; endproperty
  a_cd: assert property (p_cd) else $error("cd");
  property p_smb; !smbus_controller_req |=> !irq_pending[0]; endproperty
  a_smb: assert property (p_smb) else $error("smb");
endmodule // xiep_chk
bind xiep_ctrl xiep_chk xiep_chk_i (.*);
`default_nettype wire

/* verification/xiep_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module xiep_ctrl_tb;
  logic clk, arst_n, wr, rd, ge, ret, en;
  logic [7:0] ad, wd, ex;
  logic [10:0] f;
  wire [7:0] rdat, pn;
  wire [2:0] src;
  wire rq, hi, hs, ls, ak;
  int err_count, cmp_count, i;
  xiep_ctrl xiep_ctrl_i (.clk(clk), .arst_n(arst_n), .sfr_addr(ad), .sfr_wr(wr),
    .sfr_wdata(wd), .sfr_rd(rd), .sfr_rdata(rdat), .timer_three_low_overflow_flag(f[10]),
    .timer_three_high_overflow_flag(f[9]), .comparator_one_rising_flag(f[8]),
    .comparator_one_falling_flag(f[7]), .comparator_zero_rising_flag(f[6]),
    .comparator_zero_falling_flag(f[5]), .counter_array_req(f[4]),
    .conversion_done_flag(f[3]), .window_compare_flag(f[2]), .port_match_req(f[1]),
    .smbus_controller_req(f[0]), .global_irq_enable(ge), .irq_ack(ak), .irq_return(ret),
    .irq_req(rq), .irq_high(hi), .irq_source(src), .irq_pending(pn),
    .high_in_service(hs), .low_in_service(ls));
  xiep_core xiep_core_i (.clk(clk), .en(en), .rq(rq), .ak(ak));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Each access leaves an idle cycle so a strobe never toggles twice in one step.
  task w(input logic [7:0] a, input logic [7:0] d);
    ad = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
    @(negedge clk);
  endtask
  task r(input logic [7:0] a, input logic [7:0] e);
    ad = a;
    rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    chk(rdat, e);
    @(negedge clk);
  endtask
  initial begin
    #5000 err_count++;
    end_sim;
  end
  initial begin
    {arst_n, wr, rd, ge, ret, en} = 6'h00;
    ad = 8'h00;
    wd = 8'h00;
    f = 11'h000;
    err_count = 0;
    cmp_count = 0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    r(8'hF3, 8'h00);
    r(8'hE6, 8'h00);
    w(8'hF3, 8'hA5);
    w(8'h55, 8'h5A);
    r(8'hF3, 8'hA5);
    r(8'h55, 8'h00);
    ge = 1'b1;
    f = 11'h7FF;
    for (i = 0; i < 8; i++) begin
      w(8'hE6, 8'hFF);
      w(8'hF3, 8'h01 << i);
      chk({rq, hi, 3'h0, src}, {5'h18, i[2:0]});
      w(8'hE6, ~(8'h01 << i));
      chk(pn, ~(8'h01 << i));
    end
    w(8'hE6, 8'hFF);
    // Flags 10 and 9 feed timer three, 8 and 7 comparator one, 6 and 5 comparator zero.
    for (i = 0; i < 11; i++) begin
      f = 11'h001 << i;
      ex = 8'h01 << ((i > 4) ? (i + 5) / 2 : i);
      repeat (2) @(negedge clk);
      chk(pn, ex);
    end
    f = 11'h200;
    w(8'hE6, 8'h80);
    chk(pn, 8'h80);
    f = 11'h020;
    w(8'hE6, 8'h20);
    chk(pn, 8'h20);
    ge = 1'b0;
    repeat (2) @(negedge clk);
    chk({rq, pn[6:0]}, 8'h00);
    ge = 1'b1;
    w(8'hE6, 8'hFF);
    w(8'hF3, 8'h80);
    chk({rq, hi, 3'h0, src}, {5'h10, 3'h5});
    en = 1'b1;
    repeat (3) @(negedge clk);
    chk({6'h00, hs, ls}, 8'h01);
    f = 11'h420;
    repeat (3) @(negedge clk);
    chk({6'h00, hs, ls}, 8'h03);
    en = 1'b0;
    f = 11'h000;
    for (i = 1; i >= 0; i--) begin
      ret = 1'b1;
      @(negedge clk) ret = 1'b0;
      @(negedge clk) chk({6'h00, hs, ls}, i[7:0]);
    end
    arst_n = 1'b0;
    @(negedge clk) arst_n = 1'b1;
    r(8'hF3, 8'h00);
    end_sim;
  end
endmodule // xiep_ctrl_tb
`default_nettype wire
